// ### core/ashi_pkg.sv
// Constants and types for the serial host interface
package ashi_pkg;
    localparam int CLK_MHZ = 40;
    localparam int ICLK_HALF_NS = 50;
    localparam int ICLK_HALF_CYC = (ICLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int WORD_W = 32;
    localparam logic [5:0] MIN_WR_CLKS = 6'h20;
    localparam logic [5:0] BITS_ONE = 6'h20;
    localparam logic [5:0] BITS_TWO = 6'h10;
    localparam logic [1:0] MODE_DEFAULT = 2'h0;
    localparam logic [1:0] PROT_LEGACY = 2'h0;
    localparam logic [1:0] CFG_DUAL = 2'h3;
    localparam logic [4:0] OP_RD_HWORD = 5'h19;
    localparam logic [4:0] OP_RD_BYTE = 5'h09;
    localparam int OP_MSB = 31;
    localparam int OP_LSB = 27;
    localparam int RES_LSB = 16;
    typedef enum logic [1:0] {RSP_CONV, RSP_HWORD, RSP_BYTE} ashi_rsp_t;
endpackage

// ### core/ashi_core.sv
// Serial host interface: legacy and source-synchronous reads, command capture
// Behaviour
// - All flags on: result 31:16, address, range, supply, input alarm, parity, zeros.
// - Enabled flags pack contiguously below result; remaining low bits are zero.
// - Four clock modes set polarity and capture edge for writes.
// - After reset the low-idle rising-capture mode is used.
// - The chosen clock mode governs writes, and reads except when the internal oscillator drives the output clock.
// - First bit launches at select fall in modes 00/10 and in source-synchronous reads, first launch edge otherwise.
// - Output protocol 00 gives legacy reads; other values give source-synchronous reads.
// - In legacy modes the ready/clock pin stays low all frame.
// - Long frame with output control 00h passes input bits through, daisy-chain.
// - Two-line mode drives two bits per launch edge.
// - Same timing for one or two lines; two lines need half the clocks.
// - Source-synchronous modes drive an output clock aligned with the data.
// - Output clock comes from host clock or internal oscillator by select bit.
// - One or two lines are offered in every source-synchronous mode.
// - Frame F+1 carries register data after a read, else result with flags.
// - Configuration commands execute at the select rising edge ending the frame.
// - Flag order: address, range, supply alarm, input alarm, parity.
module ashi_core
    import ashi_pkg::*;
#(
    parameter int ICLK_HALF = ICLK_HALF_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_convert_chip_select_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic [1:0] i_input_clock_mode_sel,
    input wire logic [1:0] i_output_protocol_sel,
    input wire logic [1:0] i_second_output_cfg,
    input wire logic i_sync_clock_source_sel,
    input wire logic i_include_dev_addr,
    input wire logic i_include_range,
    input wire logic i_include_supply_alarm,
    input wire logic i_include_input_alarm,
    input wire logic i_parity_append_en,
    input wire logic [15:0] i_conv_result,
    input wire logic [3:0] i_dev_addr,
    input wire logic [3:0] i_range,
    input wire logic [1:0] i_supply_alarm,
    input wire logic [1:0] i_input_alarm,
    input wire logic i_alarm_level,
    input wire logic [15:0] i_reg_rd_data,
    input wire logic i_cmd_ready,
    output logic o_serial_out_line0,
    output logic o_shared_alarm_out_pin,
    output logic o_ready_outclk_pin,
    output logic o_cmd_valid,
    output logic [31:0] o_cmd_word,
    output logic o_cmd_space
);
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] cs_s;
        logic [1:0] sdi_s;
        logic [1:0] mode;
        logic src;
        logic int_clk;
        logic dual;
        logic daisy;
        logic [31:0] rx;
        logic [5:0] nclk;
        logic [31:0] tx;
        logic sdi_cap;
        logic first;
        logic line0;
        logic line1;
        logic ready_outclk_pin;
        ashi_rsp_t rsp;
        logic [7:0] div;
        logic [5:0] nbits;
        logic [1:0][31:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } ashi_state_t;

    ashi_state_t r_reg;
    ashi_state_t r_next;

    // Packs result and enabled flags, first flag nearest the result
    function automatic logic [31:0] pack_word(
        input logic [15:0] res,
        input logic [4:0] inc,
        input logic [3:0] addr,
        input logic [3:0] rng,
        input logic [1:0] sup,
        input logic [1:0] inp
    );
        logic [31:0] t;
        int len;
        logic [1:0] par;
        t = 32'h0;
        len = 0;
        par = {^res, ^{addr, rng, sup, inp}};
        if (inc[4])
        begin
            t = {t[27:0], addr};
            len = len + 4;
        end
        if (inc[3])
        begin
            t = {t[27:0], rng};
            len = len + 4;
        end
        if (inc[2])
        begin
            t = {t[29:0], sup};
            len = len + 2;
        end
        if (inc[1])
        begin
            t = {t[29:0], inp};
            len = len + 2;
        end
        if (inc[0])
        begin
            t = {t[29:0], par};
            len = len + 2;
        end
        t = t << (16 - len);
        return {res, t[15:0]};
    endfunction

    logic cs_fall;
    logic cs_rise;
    logic in_frame;
    logic sclk_rise;
    logic sclk_fall;
    logic cap_edge;
    logic launch_edge;
    logic tick;
    logic launch;
    logic hold_first;
    logic push;
    logic pop;
    logic [31:0] word;
    logic [4:0] incl;

    assign incl = {i_include_dev_addr, i_include_range, i_include_supply_alarm,
                   i_include_input_alarm, i_parity_append_en};

    always_comb
    begin
        r_next = r_reg;
        r_next.sclk_s = {r_reg.sclk_s[1:0], i_sclk};
        r_next.cs_s = {r_reg.cs_s[1:0], i_convert_chip_select_n};
        r_next.sdi_s = {r_reg.sdi_s[0], i_sdi};
        cs_fall = r_reg.cs_s[2] & ~r_reg.cs_s[1];
        cs_rise = ~r_reg.cs_s[2] & r_reg.cs_s[1];
        in_frame = ~r_reg.cs_s[1] & ~cs_fall;
        sclk_rise = ~r_reg.sclk_s[2] & r_reg.sclk_s[1];
        sclk_fall = r_reg.sclk_s[2] & ~r_reg.sclk_s[1];
        // Modes 00 and 11 capture on rising, 01 and 10 on falling
        cap_edge = (r_reg.mode[1] == r_reg.mode[0]) ? sclk_rise : sclk_fall;
        launch_edge = (r_reg.mode[1] == r_reg.mode[0]) ? sclk_fall : sclk_rise;
        tick = 1'b0;
        if (in_frame && r_reg.src && r_reg.int_clk && r_reg.nbits != 6'h0)
        begin
            if (r_reg.div == 8'(ICLK_HALF - 1))
            begin
                tick = 1'b1;
                r_next.div = 8'h0;
                r_next.ready_outclk_pin = ~r_reg.ready_outclk_pin;
            end
            else
            begin
                r_next.div = r_reg.div + 8'h1;
            end
        end
        // Internal clock launches on its falling half so the host can sample on rising
        launch = in_frame & (r_reg.src && r_reg.int_clk ? (tick & r_reg.ready_outclk_pin) : launch_edge);
        hold_first = r_reg.first & r_reg.mode[0] & ~r_reg.src;
        if (in_frame && cap_edge)
        begin
            r_next.rx = {r_reg.rx[30:0], r_reg.sdi_s[1]};
            r_next.sdi_cap = r_reg.sdi_s[1];
            if (r_reg.nclk != 6'h3F)
            begin
                r_next.nclk = r_reg.nclk + 6'h1;
            end
        end
        if (launch)
        begin
            r_next.first = 1'b0;
            if (!hold_first)
            begin
                if (r_reg.dual)
                begin
                    r_next.tx = {r_reg.tx[29:0], 2'b00};
                end
                else
                begin
                    r_next.tx = {r_reg.tx[30:0], r_reg.daisy & r_reg.sdi_cap};
                end
            end
            if (r_reg.nbits != 6'h0)
            begin
                r_next.nbits = r_reg.nbits - 6'h1;
            end
        end
        // External source-synchronous clock echoes the host clock
        if (in_frame && r_reg.src && !r_reg.int_clk)
        begin
            r_next.ready_outclk_pin = r_reg.sclk_s[1];
        end
        case (r_reg.rsp)
            RSP_HWORD: word = {i_reg_rd_data, 16'h0};
            RSP_BYTE: word = {i_reg_rd_data[7:0], 24'h0};
            default: word = pack_word(i_conv_result, incl, i_dev_addr, i_range,
                                      i_supply_alarm, i_input_alarm);
        endcase
        if (cs_fall)
        begin
            r_next.mode = i_input_clock_mode_sel;
            r_next.src = i_output_protocol_sel != PROT_LEGACY;
            r_next.int_clk = i_sync_clock_source_sel;
            r_next.dual = i_second_output_cfg == CFG_DUAL;
            r_next.daisy = i_output_protocol_sel == PROT_LEGACY && i_second_output_cfg != CFG_DUAL;
            r_next.tx = word;
            r_next.first = 1'b1;
            r_next.nclk = 6'h0;
            r_next.nbits = (i_second_output_cfg == CFG_DUAL) ? BITS_TWO : BITS_ONE;
            r_next.div = 8'h0;
            r_next.ready_outclk_pin = 1'b0;
        end
        push = 1'b0;
        if (cs_rise)
        begin
            r_next.ready_outclk_pin = 1'b0;
            r_next.rsp = RSP_CONV;
            // Short frames carry no command and are simply dropped
            if (r_reg.nclk >= MIN_WR_CLKS)
            begin
                push = r_reg.cnt != 2'h2;
                if (r_reg.rx[OP_MSB:OP_LSB] == OP_RD_HWORD)
                begin
                    r_next.rsp = RSP_HWORD;
                end
                else if (r_reg.rx[OP_MSB:OP_LSB] == OP_RD_BYTE)
                begin
                    r_next.rsp = RSP_BYTE;
                end
            end
        end
        if (!r_next.src)
        begin
            r_next.ready_outclk_pin = 1'b0;
        end
        pop = r_reg.cnt != 2'h0 && i_cmd_ready;
        if (push)
        begin
            r_next.mem[r_reg.wp] = r_reg.rx;
            r_next.wp = ~r_reg.wp;
        end
        if (pop)
        begin
            r_next.rp = ~r_reg.rp;
        end
        r_next.cnt = r_reg.cnt + 2'(push) - 2'(pop);
        r_next.line0 = (r_next.first & r_next.mode[0] & ~r_next.src) ? 1'b0 : r_next.tx[31];
        r_next.line1 = (r_next.first & r_next.mode[0] & ~r_next.src) ? 1'b0 : r_next.tx[30];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            r_reg <= '0;
            r_reg.cs_s <= 3'h7;
            r_reg.mode <= MODE_DEFAULT;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign o_serial_out_line0 = r_reg.line0;
    assign o_shared_alarm_out_pin = r_reg.dual ? r_reg.line1 : i_alarm_level;
    assign o_ready_outclk_pin = r_reg.ready_outclk_pin;
    assign o_cmd_valid = r_reg.cnt != 2'h0;
    assign o_cmd_word = r_reg.mem[r_reg.rp];
    // Serial source cannot stall; a full buffer drops the frame's command
    assign o_cmd_space = r_reg.cnt != 2'h2;

    a_rvs_legacy_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !r_reg.src |-> !o_ready_outclk_pin) else $error("clock pin active in legacy mode");
    a_mode_after_rst: assert property (@(posedge i_clk)
        i_sys_rst |=> r_reg.mode == MODE_DEFAULT) else $error("mode not default after reset");
    a_mode_at_fall: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        cs_fall |=> r_reg.mode == $past(i_input_clock_mode_sel)) else $error("mode not latched");
    a_cmd_long_frame: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        cs_rise && r_reg.nclk >= MIN_WR_CLKS && r_reg.cnt == 2'h0 |=> o_cmd_valid
        && o_cmd_word == $past(r_reg.rx)) else $error("command not taken at frame end");
    a_cmd_short_frame: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        cs_rise && r_reg.nclk < MIN_WR_CLKS && r_reg.cnt == 2'h0 |=> !o_cmd_valid)
        else $error("short frame produced a command");
    a_first_bit_fall: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        cs_fall && !i_input_clock_mode_sel[0] |=> o_serial_out_line0 == r_reg.tx[31])
        else $error("msb not launched at select fall");
    a_full_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        cs_fall && r_reg.rsp == RSP_CONV && &incl |=> r_reg.tx[31:2] == $past({i_conv_result,
        i_dev_addr, i_range, i_supply_alarm, i_input_alarm, ^i_conv_result,
        ^{i_dev_addr, i_range, i_supply_alarm, i_input_alarm}}) && r_reg.tx[1:0] == 2'b00)
        else $error("full flag layout wrong");
    a_dual_two_bits: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        launch && r_reg.dual && !hold_first && !cs_rise |=> r_reg.tx[31:2] == $past(r_reg.tx[29:0]))
        else $error("two-line shift wrong");
    a_shared_pin: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        cs_fall && i_second_output_cfg == CFG_DUAL && (!i_input_clock_mode_sel[0]
        || i_output_protocol_sel != PROT_LEGACY) |=> o_shared_alarm_out_pin == r_reg.tx[30])
        else $error("shared pin not line 1");
endmodule

// ### tb/ashi_host.sv
// Host controller model: drives select, serial clock and data in
module ashi_host (
    input wire logic i_clk,
    input wire logic i_line0,
    input wire logic i_line1,
    input wire logic i_outclk,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    int pulses = 0;
    logic oc_q = 1'b0;
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end
    always @(posedge i_clk)
    begin
        oc_q <= i_outclk;
        if (i_outclk && !oc_q)
            pulses <= pulses + 1;
    end
    task automatic gap();
        repeat (4) @(negedge i_clk);
    endtask
    // Long frames resend the word and rx keeps the last bits seen; mode must match the device
    task automatic frame(input logic [1:0] mode, input int n, input logic dual, input logic [31:0] tx,
                         output logic [31:0] rx, output int oc);
        int i;
        int p0;
        rx = 32'h0;
        o_sclk = mode[1];
        gap();
        p0 = pulses;
        o_cs_n = 1'b0;
        if (!mode[0])
            o_sdi = tx[31];
        gap();
        for (i = 0; i < n; i++)
        begin
            if (mode[0])
            begin
                o_sclk = ~o_sclk;
                o_sdi = tx[5'(31 - i)];
                gap();
            end
            if (dual)
            begin
                rx[5'(31 - 2 * i)] = i_line0;
                rx[5'(30 - 2 * i)] = i_line1;
            end
            else
                rx[5'(31 - i)] = i_line0;
            o_sclk = ~o_sclk;
            gap();
            if (!mode[0])
            begin
                o_sclk = ~o_sclk;
                o_sdi = tx[5'(30 - i)];
                gap();
            end
        end
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi; // Released line must not keep its last value
        gap();
        oc = pulses - p0;
        gap();
    endtask
endmodule

// ### tb/ashi_core_tb.sv
// Self-checking bench for the serial host interface
module ashi_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, cs_n, sclk, sdi, ssel = 1'b0, alarm = 1'b1, cready = 1'b1;
    logic [1:0] mode = 2'h0, prot = 2'h0, cfg = 2'h0, sup = 2'h2, inp = 2'h1;
    logic [4:0] inc = 5'h00;
    logic [3:0] addr = 4'h9, rng = 4'h6;
    logic [15:0] res = 16'hA5C3, rdd = 16'h3C7E;
    logic line0, sh, oc, cvalid, cspace;
    logic [31:0] cword, got;
    logic [31:0] q[$];
    int miscompares = 0, samples_checked = 0, pc;
    initial forever #12.5 clk = ~clk;
    always @(posedge clk)
        if (cvalid && cready)
            q.push_back(cword);
    ashi_core #(.ICLK_HALF(2)) ashi_core_i (.i_clk(clk), .i_sys_rst(rst), .i_convert_chip_select_n(cs_n),
        .i_sclk(sclk), .i_sdi(sdi), .i_input_clock_mode_sel(mode), .i_output_protocol_sel(prot),
        .i_second_output_cfg(cfg), .i_sync_clock_source_sel(ssel), .i_include_dev_addr(inc[4]),
        .i_include_range(inc[3]), .i_include_supply_alarm(inc[2]), .i_include_input_alarm(inc[1]),
        .i_parity_append_en(inc[0]), .i_conv_result(res), .i_dev_addr(addr), .i_range(rng),
        .i_supply_alarm(sup), .i_input_alarm(inp), .i_alarm_level(alarm), .i_reg_rd_data(rdd),
        .i_cmd_ready(cready), .o_serial_out_line0(line0), .o_shared_alarm_out_pin(sh),
        .o_ready_outclk_pin(oc), .o_cmd_valid(cvalid), .o_cmd_word(cword), .o_cmd_space(cspace));
    ashi_host ashi_host_i (.i_clk(clk), .i_line0(line0), .i_line1(sh), .i_outclk(oc),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] expw(input logic [4:0] f);
        int p;
        logic [31:0] w;
        p = 16;
        w = {res, 16'h0};
        if (f[4])
        begin
            p -= 4;
            w[p+:4] = addr;
        end
        if (f[3])
        begin
            p -= 4;
            w[p+:4] = rng;
        end
        if (f[2])
        begin
            p -= 2;
            w[p+:2] = sup;
        end
        if (f[1])
        begin
            p -= 2;
            w[p+:2] = inp;
        end
        if (f[0])
        begin
            p -= 2;
            w[p+:2] = {^res, ^{addr, rng, sup, inp}};
        end
        return w;
    endfunction
    task automatic fr(input int n, input logic [31:0] tx);
        ashi_host_i.frame(mode, n, cfg == 2'h3, tx, got, pc);
    endtask
    task automatic t_reset();
        chk({29'h0, line0, oc, cvalid}, 32'h0);
        chk({31'h0, sh}, {31'h0, alarm});
    endtask
    task automatic t_flags();
        inc = 5'h1F;
        fr(32, 32'h0);
        fr(32, 32'h0);
        chk(got, {res, addr, rng, sup, inp, ^res, ^{addr, rng, sup, inp}, 2'b00});
        chk(pc, 0);
        inc = 5'h0D;
        fr(32, 32'h0);
        chk(got, {res, rng, sup, ^res, ^{addr, rng, sup, inp}, 8'h00});
    endtask
    task automatic t_cmd();
        fr(32, {5'h19, 27'h0123456});
        chk(q[$], {5'h19, 27'h0123456});
        fr(32, {5'h09, 27'h0000008});
        chk(got, {rdd, 16'h0});
        fr(31, {5'h19, 27'h5});
        chk(got, {rdd[7:0], 24'h0});
        chk(q[$], {5'h09, 27'h0000008});
        fr(32, 32'h0);
        chk(got, expw(inc));
    endtask
    // Long legacy frame: input bits come back after the device word
    task automatic t_daisy();
        fr(64, 32'h1234ABCD);
        chk(got, 32'h1234ABCD);
        chk(q[$], 32'h1234ABCD);
    endtask
    task automatic t_modes();
        for (int m = 1; m < 4; m++)
        begin
            mode = m[1:0];
            fr(32, 32'h0);
            chk(got, expw(inc));
        end
        mode = 2'h0;
        fr(32, 32'h0);
        chk(got, expw(inc));
    endtask
    task automatic t_dual();
        cfg = 2'h3;
        fr(16, 32'h0);
        fr(16, 32'h0);
        chk(got, expw(inc));
        cfg = 2'h0;
        // Two-line choice stays latched until the next select fall
        @(negedge clk);
        chk({31'h0, sh}, 32'h0);
    endtask
    task automatic t_src();
        prot = 2'h1;
        fr(32, 32'h0);
        chk(pc, 32);
        ssel = 1'b1;
        fr(32, 32'h0);
        chk(pc, 32);
        cfg = 2'h3;
        fr(32, 32'h0);
        chk(pc, 16);
        cfg = 2'h0;
        prot = 2'h0;
        fr(32, 32'h0);
        chk(pc, 0);
        alarm = 1'b0;
        @(negedge clk);
        chk({31'h0, sh}, 32'h0);
    endtask
    task automatic t_buf();
        int n0 = q.size();
        cready = 1'b0;
        for (int k = 1; k < 4; k++)
            fr(32, {28'h0, k[3:0]});
        chk({30'h0, cvalid, cspace}, 32'h2);
        cready = 1'b1;
        repeat (6) @(negedge clk);
        chk(q.size() - n0, 2);
        chk(q[n0], 32'h1);
        chk(q[n0 + 1], 32'h2);
    endtask
    task automatic stop_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        t_reset();
        rst = 1'b0;
        t_flags();
        t_cmd();
        t_daisy();
        t_modes();
        t_dual();
        t_src();
        t_buf();
        stop_test();
    end
    initial
    begin
        #1000000;
        miscompares++;
        stop_test();
    end
endmodule
